// [rtl/sps_cfg.svh]
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPS_BYTE_BITS     8
`define SPS_CNT_LAST      3'h7
`define SPS_CNT_FIRST     3'h0
`define SPS_F_DONE        3
`define SPS_F_WCOL        2
`define SPS_F_MODF        1
`define SPS_F_OVR         0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SPS_RST_MODE      2'h1
`define SPS_RST_SYNC      3'h4
`define SPS_RST_BYTE      8'h00

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SPS_SYNC_STAGES   2
`define SPS_SEL_SETUP_CYC 2

`endif

// [rtl/sps_pkg.sv]
package sps_pkg;

  typedef enum logic [1:0] {
    SPS_MODE_3WIRE = 2'h0,
    SPS_MODE_4WIRE = 2'h1,
    SPS_MODE_M_LO  = 2'h2,
    SPS_MODE_M_HI  = 2'h3
  } sps_mode_e;

  typedef struct packed {
    logic done;
    logic wcol;
    logic modf;
    logic ovr;
  } sps_flags_s;

  typedef struct packed {
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] rx;
    logic       done_tgl;
    logic       start_tgl;
  } sps_link_s;

endpackage : sps_pkg

// [rtl/sps_link_if.sv]
`timescale 1ns/1ns
interface sps_link_if;
  logic       clr;
  logic [7:0] tx_byte;
  logic       done_tgl;
  logic       start_tgl;
  logic [7:0] rx_byte;

  modport core (output clr, output tx_byte, input done_tgl, input start_tgl, input rx_byte);
  modport link (input clr, input tx_byte, output done_tgl, output start_tgl, output rx_byte);
endinterface : sps_link_if

// [rtl/sps_sync.sv]
`timescale 1ns/1ns
module sps_sync #(
  parameter int unsigned     W       = 3,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  input  wire logic [W-1:0]  d,
  output logic      [W-1:0]  q
);
  logic [2*W-1:0] st_q;
  logic [2*W-1:0] st_d;

  // first stage is read only by the second
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d = {st_q[W-1:0], d};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q[2*W-1:W];
endmodule : sps_sync

// [rtl/sps_link.sv]
`timescale 1ns/1ns
`include "sps_cfg.svh"
module sps_link (
  input  wire logic link_clk,
  input  wire logic mosi,
  output logic      miso,
  sps_link_if.link  lk
);
  sps_pkg::sps_link_s st_q;
  sps_pkg::sps_link_s st_d;

  // ----------------------------------------------------------------
  // shift on every sampling edge of the master clock
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (st_q.cnt == `SPS_CNT_FIRST) begin
      st_d.sh        = {lk.tx_byte[6:0], mosi};
      st_d.start_tgl = ~st_q.start_tgl;
    end else begin
      st_d.sh = {st_q.sh[6:0], mosi};
    end
    if (st_q.cnt == `SPS_CNT_LAST) begin
      st_d.rx       = {st_q.sh[6:0], mosi};
      st_d.done_tgl = ~st_q.done_tgl;
    end
    st_d.cnt = 3'(st_q.cnt + 3'h1);
  end

  // clear is asynchronous: select high (four-wire slave only), port disable or master enable
  always_ff @(posedge link_clk or posedge lk.clr) begin
    if (lk.clr) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign miso         = (st_q.cnt == `SPS_CNT_FIRST) ? lk.tx_byte[7] : st_q.sh[7];
  assign lk.done_tgl  = st_q.done_tgl;
  assign lk.start_tgl = st_q.start_tgl;
  assign lk.rx_byte   = st_q.rx;
endmodule : sps_link

// [rtl/sps_slave.sv]
`timescale 1ns/1ns
`include "sps_cfg.svh"
module sps_slave (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso_o,
  output logic            miso_oe_n,
  input  wire logic       slave_select_in,
  input  wire logic       ctrl_wr,
  input  wire logic       port_enable_bit_in,
  input  wire logic       master_enable_bit_in,
  input  wire logic       select_mode_high_bit,
  input  wire logic       select_mode_low_bit,
  input  wire logic       clk_pol_in,
  input  wire logic       clk_pha_in,
  input  wire logic       irq_en,
  input  wire logic [3:0] flag_clr,
  input  wire logic       dat_wr,
  input  wire logic [7:0] dat_wdata,
  input  wire logic       dat_rd,
  output logic      [7:0] serial_data_register,
  output logic            byte_done_flag,
  output logic            write_collision_flag,
  output logic            mode_fault_flag,
  output logic            receive_overrun_flag,
  output logic            irq,
  output logic            transfer_busy_flag,
  output logic            selected_flag,
  output logic            select_pin_level,
  output logic            shift_empty_flag,
  output logic            rx_empty_flag,
  output logic            port_enable_bit,
  output logic            master_enable_bit
);

  // ----------------------------------------------------------------
  // core state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                port_en;
    logic                master_en;
    sps_pkg::sps_mode_e  mode;
    logic                cpol;
    logic                cpha;
    logic [7:0]          txb;
    logic                txb_full;
    logic [7:0]          txsh;
    logic                sh_full;
    logic [7:0]          rxb;
    logic                rxb_full;
    sps_pkg::sps_flags_s flags;
    logic                busy;
    logic                done_exp;
    logic                start_exp;
    logic                ssel_d;
    logic                sel;
    logic [7:0]          rd_data;
  } sps_core_s;

  sps_core_s  st_q;
  sps_core_s  st_d;
  logic [2:0] sync_q;
  logic       done_s;
  logic       start_s;
  logic       ssel_s;
  logic       done_ev;
  logic       start_ev;
  logic       link_clr;
  logic       core_clr;
  logic       modf_cond;
  logic       link_clk;

  sps_link_if lk ();

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  function automatic logic four_wire_slave(input logic master, input sps_pkg::sps_mode_e m);
    four_wire_slave = !master && (m == sps_pkg::SPS_MODE_4WIRE);
  endfunction : four_wire_slave

  function automatic logic slave_clear(input logic en, input logic master,
                                       input sps_pkg::sps_mode_e m, input logic ssel);
    slave_clear = !en || master || (four_wire_slave(master, m) && ssel);
  endfunction : slave_clear

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  sps_sync #(
    .W       (3),
    .RST_VAL (`SPS_RST_SYNC)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .d       ({slave_select_in, lk.start_tgl, lk.done_tgl}),
    .q       (sync_q)
  );

  assign ssel_s  = sync_q[2];
  assign start_s = sync_q[1];
  assign done_s  = sync_q[0];

  // link counts only while enabled slave, and in four-wire mode only while selected
  assign link_clr   = slave_clear(st_q.port_en, st_q.master_en, st_q.mode,
                                  slave_select_in);
  assign core_clr   = slave_clear(st_q.port_en, st_q.master_en, st_q.mode, ssel_s);
  assign lk.clr     = link_clr;
  assign lk.tx_byte = st_q.txsh;
  assign link_clk   = sck ^ st_q.cpol ^ st_q.cpha;
  assign done_ev    = !core_clr && (done_s != st_q.done_exp);
  assign start_ev   = !core_clr && (start_s != st_q.start_exp);
  assign modf_cond  = st_q.port_en && st_q.master_en && !ssel_s &&
                      (st_q.mode == sps_pkg::SPS_MODE_4WIRE);

  sps_link u_link (
    .link_clk (link_clk),
    .mosi     (mosi),
    .miso     (miso_o),
    .lk       (lk)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      if (ctrl_wr) begin
        st_d.port_en   = port_enable_bit_in;
        st_d.master_en = master_enable_bit_in;
        st_d.mode      = sps_pkg::sps_mode_e'({select_mode_high_bit, select_mode_low_bit});
        st_d.cpol      = clk_pol_in;
        st_d.cpha      = clk_pha_in;
      end
      // software clears first so a same-cycle set wins
      st_d.flags = sps_pkg::sps_flags_s'(st_q.flags & ~flag_clr);
      if (dat_rd) begin
        st_d.rd_data  = st_q.rxb;
        st_d.rxb_full = 1'b0;
      end
      if (core_clr) begin
        st_d.done_exp  = 1'b0;
        st_d.start_exp = 1'b0;
        st_d.busy      = 1'b0;
      end
      if (start_ev) begin
        st_d.start_exp = start_s;
        st_d.sh_full   = 1'b1;
        st_d.busy      = 1'b1;
      end
      if (done_ev) begin
        st_d.done_exp   = done_s;
        st_d.busy       = 1'b0;
        st_d.flags.done = 1'b1;
        if (st_d.rxb_full) begin
          st_d.flags.ovr = 1'b1;
        end else begin
          st_d.rxb      = lk.rx_byte;
          st_d.rxb_full = 1'b1;
        end
        if (st_q.txb_full) begin
          st_d.txsh     = st_q.txb;
          st_d.txb_full = 1'b0;
          st_d.sh_full  = 1'b1;
        end else begin
          st_d.sh_full  = 1'b0;
        end
      end
      if (dat_wr) begin
        if (st_d.txb_full) begin
          st_d.flags.wcol = 1'b1;
        end else if (!st_d.sh_full) begin
          st_d.txsh    = dat_wdata;
          st_d.sh_full = 1'b1;
        end else begin
          st_d.txb      = dat_wdata;
          st_d.txb_full = 1'b1;
        end
      end
      if (modf_cond) begin
        st_d.flags.modf = 1'b1;
        st_d.port_en    = 1'b0;
        st_d.master_en  = 1'b0;
      end
      st_d.ssel_d = ssel_s;
      if (ssel_s == st_q.ssel_d) begin
        st_d.sel = !ssel_s;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.mode     <= sps_pkg::sps_mode_e'(`SPS_RST_MODE);
      st_q.ssel_d   <= 1'b1;
      st_q.txsh     <= `SPS_RST_BYTE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign miso_oe_n            = !(st_q.port_en && !st_q.master_en &&
                                  (st_q.mode == sps_pkg::SPS_MODE_3WIRE || !ssel_s));
  assign serial_data_register = st_q.rd_data;
  assign byte_done_flag       = st_q.flags.done;
  assign write_collision_flag = st_q.flags.wcol;
  assign mode_fault_flag      = st_q.flags.modf;
  assign receive_overrun_flag = st_q.flags.ovr;
  assign irq                  = irq_en && (|st_q.flags);
  assign transfer_busy_flag   = st_q.busy;
  assign selected_flag        = st_q.sel;
  assign select_pin_level     = ssel_s;
  assign shift_empty_flag     = st_q.master_en || !st_q.sh_full;
  assign rx_empty_flag        = !st_q.rxb_full;
  assign port_enable_bit      = st_q.port_en;
  assign master_enable_bit    = st_q.master_en;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_byte_end;
    clk_en && done_ev;
  endsequence

  sequence s_sel_low;
    (clk_en && !ssel_s)[*2];
  endsequence

  a_done_sets_flag: assert property (s_byte_end |=> byte_done_flag && !transfer_busy_flag)
    else $error("done flag not set after byte end");
  a_rx_copy_in: assert property ((s_byte_end and (!st_q.rxb_full && !dat_rd))
      |=> st_q.rxb == $past(lk.rx_byte) && !rx_empty_flag)
    else $error("received byte not copied");
  a_read_returns_rx: assert property (clk_en && dat_rd
      |=> serial_data_register == $past(st_q.rxb))
    else $error("data read not from receive buffer");
  a_wcol_discard: assert property (clk_en && dat_wr && st_q.txb_full && !done_ev
      |=> write_collision_flag && st_q.txb == $past(st_q.txb))
    else $error("collision write not discarded");
  a_direct_load: assert property (clk_en && dat_wr && !st_q.txb_full && !st_q.sh_full &&
      !done_ev && !start_ev |=> st_q.txsh == $past(dat_wdata) && st_q.sh_full)
    else $error("write to empty shift not loaded");
  a_overrun_keep: assert property ((s_byte_end and (st_q.rxb_full && !dat_rd))
      |=> receive_overrun_flag && st_q.rxb == $past(st_q.rxb))
    else $error("overrun did not keep old byte");
  a_mode_fault_off: assert property (clk_en && modf_cond
      |=> mode_fault_flag && !port_enable_bit && !master_enable_bit)
    else $error("mode fault did not disable port");
  a_flag_sticky: assert property (clk_en && byte_done_flag && !flag_clr[`SPS_F_DONE]
      |=> byte_done_flag)
    else $error("done flag cleared by hardware");
  a_busy_on_start: assert property (clk_en && start_ev |=> transfer_busy_flag &&
      (!shift_empty_flag || master_enable_bit))
    else $error("busy not raised at transfer start");
  a_sel_deglitch: assert property (s_sel_low |=> selected_flag)
    else $error("selected flag not following select");
  a_master_empty: assert property (master_enable_bit |-> shift_empty_flag)
    else $error("shift empty not one in master mode");

endmodule : sps_slave

// [test/sps_master_model.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------
// far-side bus master, sole master with one slave
// ----------------------------------------------------------------
module sps_master_model (
  output logic      sck,
  output logic      mosi,
  output logic      slave_select_in,
  input  wire logic miso
);
  // one slave only on this bus, so three-wire use is legal
  initial begin
    sck             = 1'b0;
    mosi            = 1'b1;
    slave_select_in = 1'b1;
  end

  // select moves well clear of clock edges: setup and hold in ns
  task automatic sel(input logic lvl);
    #60;
    slave_select_in = lvl;
    #60;
  endtask : sel

  // msb first; data moves mid low phase, clear of both clock edges
  task automatic bits(input logic [7:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      #8 mosi = b[7-i];
      #8 sck = 1'b1;
      r = {r[6:0], miso};
      #16 sck = 1'b0;
    end
    #8 mosi = ~mosi;
  endtask : bits
endmodule : sps_master_model

// [test/spi_slave_with_flags_test.sv]
`timescale 1ns/1ns
module spi_slave_with_flags_test;
  logic       ref_clk;
  logic       rst_n;
  logic       clk_en;
  logic       clk_pol_in;
  logic       clk_pha_in;
  logic       rx_empty_flag;
  logic       sck;
  logic       mosi;
  logic       miso_o;
  logic       miso_oe_n;
  logic       slave_select_in;
  logic       ctrl_wr;
  logic       port_enable_bit_in;
  logic       master_enable_bit_in;
  logic       select_mode_high_bit;
  logic       select_mode_low_bit;
  logic       irq_en;
  logic [3:0] flag_clr;
  logic       dat_wr;
  logic [7:0] dat_wdata;
  logic       dat_rd;
  logic [7:0] serial_data_register;
  logic       byte_done_flag;
  logic       write_collision_flag;
  logic       mode_fault_flag;
  logic       receive_overrun_flag;
  logic       irq;
  logic       transfer_busy_flag;
  logic       selected_flag;
  logic       select_pin_level;
  logic       shift_empty_flag;
  logic       port_enable_bit;
  logic       master_enable_bit;
  logic [7:0] r;
  int         n_errors;
  int         checks;
  int         cyc_cnt;
  // data-out pin has a pull-up when released
  wire        miso = miso_oe_n ? 1'b1 : miso_o;

  sps_slave i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .sck(sck), .mosi(mosi),
    .miso_o(miso_o), .miso_oe_n(miso_oe_n), .slave_select_in(slave_select_in),
    .ctrl_wr(ctrl_wr), .port_enable_bit_in(port_enable_bit_in),
    .master_enable_bit_in(master_enable_bit_in),
    .select_mode_high_bit(select_mode_high_bit), .select_mode_low_bit(select_mode_low_bit),
    .clk_pol_in(clk_pol_in), .clk_pha_in(clk_pha_in), .irq_en(irq_en), .flag_clr(flag_clr),
    .dat_wr(dat_wr), .dat_wdata(dat_wdata), .dat_rd(dat_rd),
    .serial_data_register(serial_data_register), .byte_done_flag(byte_done_flag),
    .write_collision_flag(write_collision_flag), .mode_fault_flag(mode_fault_flag),
    .receive_overrun_flag(receive_overrun_flag), .irq(irq),
    .transfer_busy_flag(transfer_busy_flag), .selected_flag(selected_flag),
    .select_pin_level(select_pin_level), .shift_empty_flag(shift_empty_flag),
    .rx_empty_flag(rx_empty_flag), .port_enable_bit(port_enable_bit),
    .master_enable_bit(master_enable_bit));

  sps_master_model i_master (.sck(sck), .mosi(mosi), .slave_select_in(slave_select_in),
    .miso(miso));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // access tasks, entered and left at a falling edge
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // v = port enable, master enable, mode high, mode low
  task automatic ctrl(input logic [3:0] v);
    {port_enable_bit_in, master_enable_bit_in, select_mode_high_bit,
     select_mode_low_bit} = v;
    ctrl_wr = 1'b1;
    cyc(1);
    ctrl_wr = 1'b0;
    cyc(2);
  endtask : ctrl

  task automatic wr(input logic [7:0] b);
    dat_wdata = b;
    dat_wr    = 1'b1;
    cyc(1);
    dat_wr    = 1'b0;
    cyc(2);
  endtask : wr

  task automatic rd(input logic [7:0] e);
    dat_rd = 1'b1;
    cyc(1);
    dat_rd = 1'b0;
    cyc(2);
    chk("read data", e, serial_data_register);
  endtask : rd

  task automatic clr(input logic [3:0] m);
    flag_clr = m;
    cyc(1);
    flag_clr = 4'h0;
    cyc(2);
  endtask : clr

  // bounded wait for the byte-end flag
  task automatic wait_done();
    cyc(1);
    for (int i = 0; i < 20 && byte_done_flag !== 1'b1; i++) cyc(1);
  endtask : wait_done

  task automatic end_of_test();
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, ctrl_wr, port_enable_bit_in, master_enable_bit_in} = 4'h0;
    {select_mode_high_bit, select_mode_low_bit, irq_en, dat_wr, dat_rd} = 5'h0;
    {clk_en, clk_pol_in, clk_pha_in} = 3'h4;
    flag_clr  = 4'h0;
    dat_wdata = 8'h00;
    cyc(8);
    rst_n = 1'b1;
    cyc(1);
    chk("empty after reset", 8'h01, shift_empty_flag);
    chk("busy after reset", 8'h00, transfer_busy_flag);
    chk("pin level after reset", 8'h01, select_pin_level);
    chk("rx empty after reset", 8'h01, rx_empty_flag);
    // a write while frozen must not be taken
    clk_en = 1'b0;
    wr(8'h55);
    clk_en = 1'b1;
    chk("frozen write", 8'h01, shift_empty_flag);
    ctrl(4'h9);
    wr(8'hA5);
    chk("empty after load", 8'h00, shift_empty_flag);
    wr(8'h3C);
    wr(8'h77);
    chk("collision", 8'h01, write_collision_flag);
    i_master.sel(1'b0);
    cyc(2);
    chk("selected", 8'h01, selected_flag);
    chk("pin level low", 8'h00, select_pin_level);
    chk("out enable", 8'h00, miso_oe_n);
    i_master.bits(8'h5A, 8, r);
    i_master.sel(1'b1);
    wait_done();
    chk("first reply", 8'hA5, r);
    chk("done flag", 8'h01, byte_done_flag);
    chk("rx full", 8'h00, rx_empty_flag);
    chk("irq masked", 8'h00, irq);
    irq_en = 1'b1;
    cyc(1);
    chk("irq raised", 8'h01, irq);
    clr(4'h8);
    i_master.sel(1'b0);
    i_master.bits(8'h11, 8, r);
    i_master.sel(1'b1);
    wait_done();
    chk("second reply", 8'h3C, r);
    chk("done again", 8'h01, byte_done_flag);
    chk("overrun", 8'h01, receive_overrun_flag);
    rd(8'h5A);
    chk("rx empty after read", 8'h01, rx_empty_flag);
    clr(4'hF);
    chk("flags cleared", 8'h00, {byte_done_flag, write_collision_flag,
      receive_overrun_flag, irq});
    i_master.bits(8'hFF, 8, r);
    cyc(10);
    chk("released out", 8'h01, miso_oe_n);
    chk("no byte unselected", 8'h00, byte_done_flag);
    i_master.sel(1'b0);
    i_master.bits(8'h00, 3, r);
    i_master.sel(1'b1);
    i_master.sel(1'b0);
    fork
      i_master.bits(8'hC3, 8, r);
      begin
        #120;
        chk("busy", 8'h01, transfer_busy_flag);
      end
    join
    i_master.sel(1'b1);
    wait_done();
    rd(8'hC3);
    clr(4'hF);
    // phase changed only while the port is off, so no stray link edge
    clk_pha_in = 1'b1;
    ctrl(4'h0);
    ctrl(4'h8);
    i_master.bits(8'h96, 8, r);
    wait_done();
    chk("three-wire reply", 8'h3C, r);
    rd(8'h96);
    clr(4'hF);
    // partial byte persists and completes with later bits
    i_master.bits(8'h00, 5, r);
    i_master.bits(8'hE0, 3, r);
    wait_done();
    rd(8'h07);
    clr(4'hF);
    i_master.bits(8'h00, 5, r);
    cyc(1);
    clk_pol_in = 1'b1;
    ctrl(4'h0);
    ctrl(4'h8);
    i_master.bits(8'h69, 8, r);
    wait_done();
    rd(8'h69);
    clr(4'hF);
    ctrl(4'hD);
    chk("empty as master", 8'h01, shift_empty_flag);
    i_master.sel(1'b0);
    cyc(4);
    chk("mode fault", 8'h01, mode_fault_flag);
    chk("enables cleared", 8'h00, {port_enable_bit, master_enable_bit});
    i_master.sel(1'b1);
    cyc(2);
    end_of_test();
  end
endmodule : spi_slave_with_flags_test
